// >>> rtl/tmr_oneshot_pwm.sv
// Two-channel 16-bit down-counting timer with one-shot and PWM modes
// Functional notes
// RULE_01: One-shot counts n count-clock periods once.
// RULE_02: At zero, reload from reload, then halt.
// RULE_03: Retrigger while running reloads and restarts.
// RULE_04: One-shot start flag write triggers countdown.
// RULE_05: Clearing count start flag stops counting.
// RULE_06: One-shot raises interrupt on reaching zero.
// RULE_07: Pin is port pin or one-shot pulse.
// RULE_08: Counter register reads return undefined value.
// RULE_09: Stopped: counter write loads reload and counter.
// RULE_10: Running: counter write updates reload only.
// RULE_11: PWM runs continuously, 16-bit or 8-bit.
// RULE_12: PWM reloads at pulse rising edge.
// RULE_13: PWM ignores triggers while counting.
// RULE_14: 16-bit PWM: high n, period 65535.
// RULE_15: 8-bit PWM: high n(m+1), period 255(m+1).
// RULE_16: PWM only on channels 2 and 3.
// RULE_17: PWM interrupt on each pulse falling edge.
// RULE_18: Count clock from four prescaled sources.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "tmr_params.svh"

module tmr_oneshot_pwm (
    input  wire logic                     clk_in, // 20 MHz system clock
    input  wire logic                     reset_in, // Synchronous reset, active high
    input  wire tmr_pkg::tmr_bus_req_type bus_in, // Register request
    output logic [15:0]                   rdata_out, // Read data, cycle after read strobe
    input  wire logic [1:0]               trigger_in, // External triggers, channels 2 and 3
    input  wire logic                     subclock_in, // Subclock, sampled on clk_in
    input  wire logic                     channel2_pulse_pin_in, // Channel 2 pin level
    output logic                          channel2_pulse_pin_out, // Channel 2 pin drive value
    output logic                          channel2_pulse_pin_oe_out, // Channel 2 pin output enable
    input  wire logic                     channel3_pulse_pin_in, // Channel 3 pin level
    output logic                          channel3_pulse_pin_out, // Channel 3 pin drive value
    output logic                          channel3_pulse_pin_oe_out, // Channel 3 pin output enable
    output logic                          irq_out // Level interrupt request
);
    import tmr_pkg::*;

    localparam int NCH = `TMR_NUM_CH;
    localparam int NEV = `TMR_NUM_CH * `TMR_EV_PER_CH;

    // Shared register state
    logic [NCH-1:0] start_flag;
    logic [NCH-1:0] port_data;
    logic [NCH-1:0] port_dir;
    logic [NEV-1:0] irq_stat;
    logic [NEV-1:0] irq_en;
    logic [NEV-1:0] irq_event;
    logic [NEV-1:0] next_irq_stat;

    // Prescaler state
    logic [4:0]     pre_cnt;
    logic [4:0]     sub_cnt;
    logic           sub_prev;
    logic           tick_div1;
    logic           tick_div8;
    logic           tick_div32;
    logic           subclock_div32;
    logic           sub_rise;

    // Per-channel results for the read mux and pins
    logic [15:0]     ch_rdata [NCH];
    logic [NCH-1:0]  ch_hit;
    logic [NCH-1:0]  ch_running;
    tmr_pin_type     ch_pin [NCH];
    logic [NCH-1:0]  pin_level;

    // Register decode
    wire  wr_start   = bus_in.wr && (bus_in.addr == `TMR_ADDR_START);
    wire  wr_oneshot = bus_in.wr && (bus_in.addr == `TMR_ADDR_ONESHOT);
    wire  wr_port    = bus_in.wr && (bus_in.addr == `TMR_ADDR_PORT);
    wire  wr_irq_clr = bus_in.wr && (bus_in.addr == `TMR_ADDR_IRQ_CLR);
    wire  wr_irq_en  = bus_in.wr && (bus_in.addr == `TMR_ADDR_IRQ_EN);

    // Prescaled count clocks, one-cycle enables at the system clock rate
    assign tick_div1      = 1'b1; // [RULE_18]
    assign tick_div8      = (pre_cnt & `TMR_DIV8_MASK) == `TMR_DIV8_MASK; // [RULE_18]
    assign tick_div32     = (pre_cnt & `TMR_DIV32_MASK) == `TMR_DIV32_MASK; // [RULE_18]
    assign sub_rise       = subclock_in && !sub_prev;
    assign subclock_div32 = sub_rise && (sub_cnt == `TMR_SUB32_LAST); // [RULE_18]

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pre_cnt  <= 5'h00;
            sub_cnt  <= 5'h00;
            sub_prev <= 1'b0;
        end else begin
            pre_cnt  <= pre_cnt + 5'h01;
            sub_prev <= subclock_in;
            if (sub_rise) begin
                sub_cnt <= sub_cnt + 5'h01;
            end
        end
    end

    assign pin_level = {channel3_pulse_pin_in, channel2_pulse_pin_in};

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            localparam int          CHAN   = `TMR_FIRST_CHAN + c;
            localparam logic        PWM_OK = (CHAN == `TMR_PWM_CHAN_A) || (CHAN == `TMR_PWM_CHAN_B);
            localparam logic [7:0]  A_MODE = `TMR_ADDR_CH_BASE + 8'(c) * `TMR_CH_STRIDE;
            localparam logic [7:0]  A_CNT  = A_MODE + `TMR_CH_CNT_OFS;

            tmr_mode_type   mode;
            tmr_state_type  state;
            tmr_state_type  next_state;
            logic [15:0]    reload;
            logic [15:0]    count;
            logic [15:0]    next_count;
            logic [15:0]    pos;
            logic [15:0]    next_pos;
            logic [7:0]     unit;
            logic [7:0]     next_unit;
            logic           pulse;
            logic           next_pulse;
            logic           trig_prev;
            logic           ev_zero;
            logic           ev_fall;

            wire         wr_mode   = bus_in.wr && (bus_in.addr == A_MODE);
            wire         wr_cnt    = bus_in.wr && (bus_in.addr == A_CNT);
            wire         is_shot   = mode.op == `TMR_OP_ONESHOT;
            wire         is_pwm    = (mode.op == `TMR_OP_PWM) && PWM_OK; // [RULE_16]
            wire         ext_trig  = mode.ext_trig && trigger_in[c] && !trig_prev;
            wire         sw_trig   = wr_oneshot && bus_in.wdata[c]; // [RULE_04]
            wire         trigger   = ext_trig || sw_trig;
            wire         run_ok    = start_flag[c]; // [RULE_05]
            wire         idle      = state == TMR_ST_IDLE;
            wire [15:0]  period    = mode.pwm8 ? `TMR_PWM8_PERIOD : `TMR_PWM16_PERIOD; // [RULE_14] [RULE_15]
            wire [15:0]  high_val  = mode.pwm8 ? {8'h00, reload[15:8]} : reload;      // [RULE_15]
            wire         pos_last  = pos == (period - `TMR_ONE16);

            // Selected count clock for this channel
            wire         tick      = (mode.src == `TMR_SRC_DIV1)  ? tick_div1  :
                                     (mode.src == `TMR_SRC_DIV8)  ? tick_div8  :
                                     (mode.src == `TMR_SRC_DIV32) ? tick_div32 :
                                                                   subclock_div32; // [RULE_18]
            // 8-bit PWM advances one unit every m+1 count clocks
            wire         unit_tick = mode.pwm8 ? (tick && unit == 8'h00) : tick;  // [RULE_15]

            always_comb begin
                next_state = state;
                next_count = count;
                next_pos   = pos;
                next_unit  = unit;
                next_pulse = pulse;
                ev_zero    = 1'b0;
                ev_fall    = 1'b0;
                if (tick && mode.pwm8) begin
                    next_unit = (unit == 8'h00) ? reload[7:0] : unit - 8'h01;
                end
                unique case (state)
                    TMR_ST_IDLE: begin
                        next_pulse = 1'b0;
                        if (wr_cnt) begin
                            next_count = bus_in.wdata; // [RULE_09]
                        end
                        if (run_ok && is_pwm) begin
                            next_state = TMR_ST_PWM; // [RULE_11]
                            next_pos   = `TMR_ZERO16;
                            next_unit  = reload[7:0];
                            next_count = high_val;
                            next_pulse = high_val != `TMR_ZERO16;
                        end else if (run_ok && is_shot && trigger) begin
                            next_state = TMR_ST_SHOT; // [RULE_01] [RULE_04]
                            next_count = reload;
                            next_pulse = 1'b1;
                        end
                    end
                    TMR_ST_SHOT: begin
                        if (!run_ok || !is_shot) begin
                            next_state = TMR_ST_IDLE; // [RULE_05]
                            next_pulse = 1'b0;
                        end else if (trigger) begin
                            next_count = reload; // [RULE_03]
                            next_pulse = 1'b1;
                        end else if (tick) begin
                            if (count <= `TMR_ONE16) begin
                                next_count = reload; // [RULE_02] [RULE_10]
                                next_state = TMR_ST_IDLE; // [RULE_02]
                                next_pulse = 1'b0;
                                ev_zero    = 1'b1; // [RULE_06]
                            end else begin
                                next_count = count - `TMR_ONE16; // [RULE_01]
                            end
                        end
                    end
                    TMR_ST_PWM: begin
                        if (!run_ok || !is_pwm) begin
                            next_state = TMR_ST_IDLE; // [RULE_05]
                            next_pulse = 1'b0;
                        end else if (unit_tick) begin // [RULE_13]
                            if (pos_last) begin
                                next_pos   = `TMR_ZERO16;
                                next_count = high_val; // [RULE_12] [RULE_10]
                                next_pulse = high_val != `TMR_ZERO16; // [RULE_12]
                            end else begin
                                next_pos = pos + `TMR_ONE16; // [RULE_14]
                                if (count != `TMR_ZERO16) begin
                                    next_count = count - `TMR_ONE16; // [RULE_12]
                                end
                                if (count == `TMR_ONE16 && pulse) begin
                                    next_pulse = 1'b0; // [RULE_14] [RULE_15]
                                    ev_fall    = 1'b1; // [RULE_17]
                                end
                            end
                        end
                    end
                    default: begin
                        next_state = TMR_ST_IDLE;
                        next_pulse = 1'b0;
                    end
                endcase
            end

            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    state     <= TMR_ST_IDLE;
                    mode      <= `TMR_MODE_RESET;
                    reload    <= `TMR_CNT_RESET;
                    count     <= `TMR_CNT_RESET;
                    pos       <= `TMR_ZERO16;
                    unit      <= 8'h00;
                    pulse     <= 1'b0;
                    trig_prev <= 1'b0;
                end else begin
                    state     <= next_state;
                    count     <= next_count;
                    pos       <= next_pos;
                    unit      <= next_unit;
                    pulse     <= next_pulse;
                    trig_prev <= trigger_in[c];
                    if (wr_mode) begin
                        mode <= bus_in.wdata[7:0];
                    end
                    if (wr_cnt) begin
                        reload <= bus_in.wdata; // [RULE_09] [RULE_10]
                    end
                end
            end

            // Pulse output: always in PWM, else by pulse-enable, else port pin
            assign ch_pin[c].out = (is_pwm || mode.pulse_en) ? pulse : port_data[c]; // [RULE_07] [RULE_16]
            assign ch_pin[c].oe  = is_pwm || mode.pulse_en || port_dir[c];           // [RULE_07]

            assign ch_running[c] = !idle;
            assign irq_event[c*`TMR_EV_PER_CH + `TMR_EV_ZERO] = ev_zero;
            assign irq_event[c*`TMR_EV_PER_CH + `TMR_EV_FALL] = ev_fall;

            // The live count is never visible on the counter register
            assign ch_hit[c]   = (bus_in.addr == A_MODE) || (bus_in.addr == A_CNT);
            assign ch_rdata[c] = (bus_in.addr == A_MODE) ? {8'h00, mode} : `TMR_UNDEF_READ; // [RULE_08]
        end
    endgenerate

    // Sticky status: a new event wins over a simultaneous clear
    assign next_irq_stat = (irq_stat & ~(wr_irq_clr ? bus_in.wdata[NEV-1:0] : {NEV{1'b0}})) | irq_event;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            start_flag <= '0;
            port_data  <= '0;
            port_dir   <= '0;
            irq_stat   <= '0;
            irq_en     <= '0;
        end else begin
            irq_stat <= next_irq_stat; // [RULE_06] [RULE_17]
            if (wr_start) begin
                start_flag <= bus_in.wdata[NCH-1:0]; // [RULE_05]
            end
            if (wr_port) begin
                port_data <= bus_in.wdata[NCH-1:0];
                port_dir  <= bus_in.wdata[`TMR_PORT_DIR_LSB +: NCH];
            end
            if (wr_irq_en) begin
                irq_en <= bus_in.wdata[NEV-1:0];
            end
        end
    end

    assign irq_out = |(irq_stat & irq_en);

    // Read mux
    logic [15:0] rd_val;
    assign rd_val =
        (bus_in.addr == `TMR_ADDR_START)    ? {14'h0000, start_flag} :
        (bus_in.addr == `TMR_ADDR_PORT)     ? {12'h000, port_dir, port_data} :
        (bus_in.addr == `TMR_ADDR_PIN)      ? {12'h000, ch_running, pin_level} :
        (bus_in.addr == `TMR_ADDR_IRQ_STAT) ? {12'h000, irq_stat} :
        (bus_in.addr == `TMR_ADDR_IRQ_EN)   ? {12'h000, irq_en} :
        ch_hit[0]                           ? ch_rdata[0] :
        ch_hit[1]                           ? ch_rdata[1] :
                                              16'h0000;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rdata_out <= 16'h0000;
        end else begin
            rdata_out <= bus_in.rd ? rd_val : 16'h0000;
        end
    end

    assign channel2_pulse_pin_out    = ch_pin[0].out;
    assign channel2_pulse_pin_oe_out = ch_pin[0].oe;
    assign channel3_pulse_pin_out    = ch_pin[1].out;
    assign channel3_pulse_pin_oe_out = ch_pin[1].oe;

endmodule

// >>> rtl/tmr_params.svh
// Register map, field positions, reset values and count constants of the timer block
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// Register byte addresses
`define TMR_ADDR_START      8'h00
`define TMR_ADDR_ONESHOT    8'h04
`define TMR_ADDR_PORT       8'h08
`define TMR_ADDR_PIN        8'h0c
`define TMR_ADDR_IRQ_STAT   8'h10
`define TMR_ADDR_IRQ_CLR    8'h14
`define TMR_ADDR_IRQ_EN     8'h18
`define TMR_ADDR_CH_BASE    8'h20
`define TMR_CH_STRIDE       8'h08
`define TMR_CH_CNT_OFS      8'h04

// Channels and geometry
`define TMR_NUM_CH          2
`define TMR_FIRST_CHAN      2
`define TMR_PWM_CHAN_A      2
`define TMR_PWM_CHAN_B      3
`define TMR_EV_PER_CH       2
`define TMR_EV_ZERO         0
`define TMR_EV_FALL         1
`define TMR_PORT_DIR_LSB    2

// Mode field encodings
`define TMR_OP_ONESHOT      2'h2
`define TMR_OP_PWM          2'h3
`define TMR_SRC_DIV1        2'h0
`define TMR_SRC_DIV8        2'h1
`define TMR_SRC_DIV32       2'h2

// Prescaler and PWM counts
`define TMR_DIV8_MASK       5'h07
`define TMR_DIV32_MASK      5'h1f
`define TMR_SUB32_LAST      5'h1f
`define TMR_PWM16_PERIOD    16'hffff
`define TMR_PWM8_PERIOD     16'h00ff

// Reset and read values
`define TMR_MODE_RESET      8'h00
`define TMR_CNT_RESET       16'h0000
`define TMR_UNDEF_READ      16'h0000
`define TMR_ZERO16          16'h0000
`define TMR_ONE16           16'h0001

`endif

// >>> rtl/tmr_pkg.sv
// Types shared by the timer block and its environment
package tmr_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } tmr_bus_req_type;

    typedef struct packed {
        logic [1:0] src;
        logic       rsvd;
        logic       pwm8;
        logic       ext_trig;
        logic       pulse_en;
        logic [1:0] op;
    } tmr_mode_type;

    typedef struct packed {
        logic out;
        logic oe;
    } tmr_pin_type;

    typedef enum logic [2:0] {
        TMR_ST_IDLE = 3'b001,
        TMR_ST_SHOT = 3'b010,
        TMR_ST_PWM  = 3'b100
    } tmr_state_type;

endpackage

// >>> tb/tmr_oneshot_pwm_checker.sv
// Port-level assertions for the two-channel one-shot and PWM timer
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_oneshot_pwm_checker
    import tmr_pkg::*;
(
    input wire logic                     clk_in, // Clock
    input wire logic                     reset_in, // Reset
    input wire tmr_pkg::tmr_bus_req_type bus_in, // Register request
    input wire logic [15:0]              rdata_out, // Read data
    input wire logic                     channel2_pulse_pin_out, // Channel 2 drive
    input wire logic                     channel2_pulse_pin_oe_out, // Channel 2 enable
    input wire logic                     channel3_pulse_pin_oe_out, // Channel 3 enable
    input wire logic                     irq_out // Interrupt
);
    tmr_mode_type mode2;
    tmr_mode_type mode3;
    logic [3:0]   port;
    logic [3:0]   irq_en;
    logic [1:0]   start;

    // Shadow of the software-written control registers
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mode2  <= '0;
            mode3  <= '0;
            port   <= 4'h0;
            irq_en <= 4'h0;
            start  <= 2'h0;
        end else if (bus_in.wr) begin
            case (bus_in.addr)
                `TMR_ADDR_START:   start  <= bus_in.wdata[1:0];
                `TMR_ADDR_PORT:    port   <= bus_in.wdata[3:0];
                `TMR_ADDR_IRQ_EN:  irq_en <= bus_in.wdata[3:0];
                `TMR_ADDR_CH_BASE: mode2  <= bus_in.wdata[7:0];
                8'h28:             mode3  <= bus_in.wdata[7:0];
                default:           ;
            endcase
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    AST_CNT_READ_UNDEF: assert property (bus_in.rd && (bus_in.addr == 8'h24 || bus_in.addr == 8'h2c)
        |=> rdata_out == 16'h0000) else $error("Counter read showed a live count");
    AST_OE_PWM2: assert property (mode2.op == `TMR_OP_PWM |-> channel2_pulse_pin_oe_out)
        else $error("Channel 2 pin not driven in PWM");
    AST_OE_PWM3: assert property (mode3.op == `TMR_OP_PWM |-> channel3_pulse_pin_oe_out)
        else $error("Channel 3 pin not driven in PWM");
    AST_PORT_PIN: assert property (mode2.op != `TMR_OP_PWM && !mode2.pulse_en && $stable(port)
        && $stable(mode2) |-> channel2_pulse_pin_oe_out == port[2] && channel2_pulse_pin_out == port[0])
        else $error("Channel 2 pin does not follow port bits");
    AST_SHOT_START: assert property (bus_in.wr && bus_in.addr == `TMR_ADDR_ONESHOT && bus_in.wdata[0]
        && start[0] && mode2.op == `TMR_OP_ONESHOT && mode2.pulse_en |=> channel2_pulse_pin_out)
        else $error("Software trigger did not raise the pulse");
    AST_STOP: assert property (bus_in.wr && bus_in.addr == `TMR_ADDR_START && !bus_in.wdata[0]
        && mode2.op[1] && (mode2.pulse_en || mode2.op[0]) |-> ##2 !channel2_pulse_pin_out)
        else $error("Pulse kept running after stop");
    AST_IRQ_MASKED: assert property (irq_en == 4'h0 |-> !irq_out)
        else $error("Interrupt raised while all sources masked");
    AST_SHOT_IRQ: assert property ($fell(channel2_pulse_pin_out) && start[0] && $stable(start)
        && $stable(mode2) && mode2.op == `TMR_OP_ONESHOT && mode2.pulse_en && irq_en[0] |-> irq_out)
        else $error("No interrupt at one-shot end");
    AST_PWM_FALL_IRQ: assert property ($fell(channel2_pulse_pin_out) && start[0] && $stable(start)
        && $stable(mode2) && mode2.op == `TMR_OP_PWM && irq_en[1] |-> irq_out)
        else $error("No interrupt at PWM falling edge");

    COV_SHOT_END: cover property ($fell(channel2_pulse_pin_out) && mode2.op == `TMR_OP_ONESHOT);
    COV_PWM_FALL: cover property ($fell(channel2_pulse_pin_out) && mode2.op == `TMR_OP_PWM);
    COV_CNT_READ: cover property (bus_in.rd && bus_in.addr == 8'h24);
endmodule

bind tmr_oneshot_pwm tmr_oneshot_pwm_checker u_chk (.clk_in, .reset_in, .bus_in, .rdata_out,
    .channel2_pulse_pin_out, .channel2_pulse_pin_oe_out, .channel3_pulse_pin_oe_out, .irq_out);

// >>> tb/tmr_pin_partner.sv
// Board model around the timer: trigger source and pull-up pin wiring
`timescale 1ns/1ps
module tmr_pin_partner (
    input  wire logic       clk_in,      // System clock
    input  wire logic [1:0] fire_in,     // Request a trigger per channel
    input  wire logic       slow_in,     // Stretch triggers to three cycles
    input  wire logic [1:0] drv_in,      // Pin drive values
    input  wire logic [1:0] oe_in,       // Pin output enables
    output logic      [1:0] trigger_out, // Trigger lines
    output logic      [1:0] pin_out      // Resolved pin levels
);
    int hold [2] = '{0, 0};

    // A released pin floats up through its pull-up
    assign pin_out = (drv_in & oe_in) | ~oe_in;

    initial trigger_out = 2'h0;
    always @(posedge clk_in) begin
        for (int c = 0; c < 2; c++) begin
            if (fire_in[c]) hold[c] <= slow_in ? 3 : 1;
            else if (hold[c] > 0) hold[c] <= hold[c] - 1;
            trigger_out[c] <= fire_in[c] || hold[c] > 1;
        end
    end
endmodule

// >>> tb/test_tmr_oneshot_pwm.sv
// Self-checking bench for the two-channel one-shot and PWM timer
`timescale 1ns/1ps
`include "tmr_params.svh"
module test_tmr_oneshot_pwm;
    import tmr_pkg::*;
    logic            clk_in = 1'b0;
    logic            reset_in = 1'b1;
    tmr_bus_req_type bus_in = '0;
    logic [15:0]     rdata_out;
    logic [1:0]      trigger_in, pin_lvl;
    logic [1:0]      fire = 2'h0;
    logic            subclock_in = 1'b0;
    logic            slow = 1'b0;
    logic            p2, p3, oe2, oe3, irq_out;
    wire  [1:0]      pins = {p3, p2};
    int              miscompares = 0;
    int              cmp_count = 0;
    int              seed = 32'h02bd;
    int              exp_q [$];
    int              unit [4] = '{1, 8, 32, 64};
    logic [7:0]      rst_addr [8] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h24, 8'h3c};

    tmr_oneshot_pwm u_dut (.clk_in, .reset_in, .bus_in, .rdata_out, .trigger_in, .subclock_in,
        .channel2_pulse_pin_in(pin_lvl[0]), .channel2_pulse_pin_out(p2), .channel2_pulse_pin_oe_out(oe2),
        .channel3_pulse_pin_in(pin_lvl[1]), .channel3_pulse_pin_out(p3), .channel3_pulse_pin_oe_out(oe3), .irq_out);
    tmr_pin_partner u_far (.clk_in, .fire_in(fire), .slow_in(slow), .drv_in(pins),
        .oe_in({oe3, oe2}), .trigger_out(trigger_in), .pin_out(pin_lvl));

    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) subclock_in <= ~subclock_in;

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus_in.wr <= 1'b0;
    endtask
    task automatic rdchk(string what, logic [7:0] a, logic [15:0] e);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus_in.rd <= 1'b0;
        @(negedge clk_in);
        check(what, {16'h0000, rdata_out}, {16'h0000, e});
    endtask
    // A limit from 1 to 999 skips the PWM pulse in progress first
    task automatic width(int c, int lim, output int hi, output int lo);
        int w = 0;
        hi = 0;
        lo = 0;
        @(negedge clk_in);
        while (lim > 0 && lim < 1000 && pins[c] === 1'b1 && w < 70000) begin @(negedge clk_in); w++; end
        while (pins[c] !== 1'b1 && w < 70000) begin @(negedge clk_in); w++; end
        while (pins[c] === 1'b1 && hi < 70000) begin hi++; @(negedge clk_in); end
        while (pins[c] === 1'b0 && lo < lim) begin lo++; @(negedge clk_in); end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end
        else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk_in);
        miscompares++;
        tally_and_finish;
    end

    initial begin
        int hi, lo, n;
        logic [15:0] d;
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        foreach (rst_addr[i]) rdchk("reset value", rst_addr[i], 16'h0000);
        d = 16'($random(seed)) & 16'h00ff;
        wr(8'h20, d);
        rdchk("mode readback", 8'h20, d);
        wr(`TMR_ADDR_IRQ_EN, 16'h0003);
        wr(`TMR_ADDR_START, 16'h0001);
        foreach (unit[s]) begin
            wr(8'h20, {8'h00, 2'(s), 6'h06});
            wr(8'h24, 16'h0003);
            wr(`TMR_ADDR_ONESHOT, 16'h0001);
            width(0, 0, hi, lo);
            check("shot width", 32'(hi > 2 * unit[s] && hi <= 3 * unit[s]), 32'h1);
            check("zero irq", 32'(irq_out), 32'h1);
            rdchk("irq status", `TMR_ADDR_IRQ_STAT, 16'h0001);
            wr(`TMR_ADDR_IRQ_CLR, 16'h0001);
        end
        @(negedge clk_in) check("irq cleared", 32'(irq_out), 32'h0);
        $display("test done: one-shot sources");
        wr(8'h20, 16'h0006);
        wr(8'h24, 16'h0006);
        fork
            width(0, 0, hi, lo);
            begin wr(`TMR_ADDR_ONESHOT, 16'h0001); repeat (2) @(posedge clk_in); wr(`TMR_ADDR_ONESHOT, 16'h0001); end
        join
        check("retrigger width", hi, 32'd10);
        fork
            width(0, 0, hi, lo);
            begin wr(`TMR_ADDR_ONESHOT, 16'h0001); wr(8'h24, 16'h0002); end
        join
        check("running write width", hi, 32'd6);
        wr(`TMR_ADDR_ONESHOT, 16'h0001);
        width(0, 0, hi, lo);
        check("reloaded width", hi, 32'd2);
        repeat (3) begin
            exp_q.push_back((32'($random(seed)) & 32'h1f) + 1);
            wr(8'h24, 16'(exp_q[$]));
            wr(`TMR_ADDR_ONESHOT, 16'h0001);
            width(0, 0, hi, lo);
            check("random width", hi, exp_q.pop_front());
        end
        wr(8'h20, 16'h000e);
        wr(8'h24, 16'h0005);
        slow <= 1'b1;
        @(posedge clk_in) fire <= 2'h1;
        @(posedge clk_in) fire <= 2'h0;
        width(0, 0, hi, lo);
        check("ext width", hi, 32'd5);
        $display("test done: one-shot triggers");
        wr(`TMR_ADDR_IRQ_CLR, 16'h000f);
        wr(8'h20, 16'h0006);
        wr(8'h24, 16'h0028);
        wr(`TMR_ADDR_ONESHOT, 16'h0001);
        rdchk("counter read", 8'h24, 16'h0000);
        wr(`TMR_ADDR_START, 16'h0000);
        repeat (2) @(negedge clk_in);
        check("stopped pin", 32'(p2), 32'h0);
        rdchk("no stop irq", `TMR_ADDR_IRQ_STAT, 16'h0000);
        $display("test done: stop");
        wr(8'h24, 16'h0301);
        wr(8'h20, 16'h0013);
        wr(`TMR_ADDR_START, 16'h0001);
        width(0, 600, hi, lo);
        check("pwm8 high", hi, 32'd6);
        check("pwm8 low", lo, 32'd504);
        check("pwm irq", 32'(irq_out), 32'h1);
        rdchk("pwm irq status", `TMR_ADDR_IRQ_STAT, 16'h0002);
        slow <= 1'b0;
        fork
            width(0, 800, hi, lo);
            begin wr(8'h24, 16'h0502); fire <= 2'h1; wr(`TMR_ADDR_ONESHOT, 16'h0001); fire <= 2'h0; end
        join
        check("pwm8 new high", hi, 32'd15);
        check("pwm8 new low", lo, 32'd750);
        wr(`TMR_ADDR_START, 16'h0000);
        wr(8'h28, 16'h0003);
        wr(8'h2c, 16'h0005);
        wr(`TMR_ADDR_START, 16'h0002);
        check("ch3 pwm drive", 32'(oe3), 32'h1);
        width(1, 70000, hi, lo);
        check("pwm16 high", hi, 32'd5);
        check("pwm16 low", lo, 32'd65530);
        $display("test done: pwm");
        wr(`TMR_ADDR_START, 16'h0000);
        wr(8'h20, 16'h0000);
        wr(8'h28, 16'h0000);
        wr(`TMR_ADDR_PORT, 16'h0005);
        repeat (2) @(negedge clk_in);
        check("port drive", {30'h0, oe2, p2}, 32'h3);
        wr(`TMR_ADDR_PORT, 16'h0000);
        rdchk("released pins", `TMR_ADDR_PIN, 16'h0003);
        wr(`TMR_ADDR_PORT, 16'h0004);
        rdchk("driven low pin", `TMR_ADDR_PIN, 16'h0002);
        $display("test done: port pin");
        tally_and_finish;
    end
endmodule
